// File: logic/lctrf_pkg.sv
// Shared constants for the cycle timer and upper request filter block
package lctrf_pkg;
  // Register byte offsets
  localparam logic [11:0] OFF_CYCLE_TIME = 12'h0f0;
  localparam logic [11:0] OFF_FILT_SET = 12'h100;
  localparam logic [11:0] OFF_FILT_CLEAR = 12'h104;
  localparam logic [11:0] OFF_TIMER_CTRL = 12'h110;
  localparam logic [11:0] OFF_TIMER_STATUS = 12'h114;
  localparam logic [11:0] OFF_REFUSED_COUNT = 12'h118;

  // Cycle timer field layout
  localparam int OFFSET_LSB = 0;
  localparam int OFFSET_MSB = 11;
  localparam int CYCLE_LSB = 12;
  localparam int CYCLE_MSB = 24;
  localparam int SECONDS_LSB = 25;
  localparam int SECONDS_MSB = 31;
  localparam int OFFSET_W = OFFSET_MSB - OFFSET_LSB + 1;
  localparam int CYCLE_W = CYCLE_MSB - CYCLE_LSB + 1;
  localparam int SECONDS_W = SECONDS_MSB - SECONDS_LSB + 1;

  // Field moduli
  localparam logic [OFFSET_W:0] OFFSET_MOD = 13'h0c00;
  localparam logic [CYCLE_W:0] CYCLE_MOD = 14'h1f40;
  localparam logic [SECONDS_W:0] SECONDS_MOD = 8'h80;

  // Rates: offset ticks come from a fractional accumulator on clk
  localparam int CLK_HZ = 20000000;
  localparam int OFFSET_HZ = 24576000;
  localparam int RATE_GCD = 4000;
  localparam int FRAC_W = 13;
  localparam logic [FRAC_W:0] FRAC_DEN = (FRAC_W + 1)'(CLK_HZ / RATE_GCD);
  localparam logic [FRAC_W:0] FRAC_NUM = (FRAC_W + 1)'((OFFSET_HZ - CLK_HZ) / RATE_GCD);

  // Control register bits
  localparam int CTRL_COUNT_EN = 0;
  localparam int CTRL_CYCLE_MASTER = 1;
  localparam int CTRL_EXT_CLOCK = 2;
  localparam logic [2:0] CTRL_RESET = 3'h0;

  // Status register bits, write one to clear
  localparam int STAT_EXT_TICK = 0;
  localparam int STAT_CS_RX = 1;
  localparam int STAT_CS_TX = 2;

  // Request filter layout
  localparam int FILT_REMOTE_BIT = 31;
  localparam logic [31:0] FILT_RESET = 32'h0000_0000;
  localparam int NODE_W = 6;
  localparam int BUS_W = 10;
  localparam logic [5:0] NODE_UPPER_BASE = 6'h20;
  localparam logic [5:0] NODE_BROADCAST = 6'h3f;
  localparam logic [9:0] BUS_LOCAL_ALIAS = 10'h3ff;
  localparam int REFUSED_W = 16;
endpackage

// File: logic/lctrf_req_filter.sv
// Source node check for incoming asynchronous requests
`timescale 1ns/100ps
module lctrf_req_filter (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [31:0] filter_bits,
  input wire logic [9:0] local_bus,
  input wire logic low_half_accept,
  input wire logic pkt_valid,
  input wire logic pkt_to_req_ctx,
  input wire logic [15:0] pkt_src_id,
  output logic decide_valid,
  output logic decide_accept
);
  logic [lctrf_pkg::BUS_W-1:0] src_bus;
  logic [lctrf_pkg::NODE_W-1:0] src_node;
  logic is_local;
  logic accept_now;

  assign src_bus = pkt_src_id[15:lctrf_pkg::NODE_W];
  assign src_node = pkt_src_id[lctrf_pkg::NODE_W-1:0];
  // Bus 3ffh always names the local bus
  assign is_local = (src_bus == local_bus) || (src_bus == lctrf_pkg::BUS_LOCAL_ALIAS);

  // Decision per packet; only request-bound traffic is filtered
  always_comb
  begin
    accept_now = 1'b1;
    if (pkt_to_req_ctx)
    begin
      if (!is_local)
        accept_now = filter_bits[lctrf_pkg::FILT_REMOTE_BIT];
      else if (src_node == lctrf_pkg::NODE_BROADCAST)
        accept_now = 1'b0; // No filter bit exists for node 63
      else if (src_node >= lctrf_pkg::NODE_UPPER_BASE)
        accept_now = filter_bits[src_node[4:0]];
      else
        accept_now = low_half_accept;
    end
  end

  // Registered verdict; a zero here means no ack and no queueing
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      decide_valid <= 1'b0;
      decide_accept <= 1'b0;
    end
    else
    begin
      decide_valid <= pkt_valid;
      decide_accept <= pkt_valid && accept_now;
    end
  end
endmodule

// File: logic/lctrf_top.sv
// Isochronous cycle timer and upper asynchronous request filter
// What this block does
// - As cycle master the current timer value goes out in each transmitted cycle start.
// - When not cycle master each received cycle start overwrites the timer, unless software writes the timer in that cycle.
// - With counting enabled and no cycle start arriving, the timer keeps advancing.
// - The offset field in bits 11..0 counts 24.576 MHz ticks and wraps at 3072.
// - The cycle field in bits 24..12 steps on each offset wrap and wraps at 8000.
// - The seconds field in bits 31..25 steps on each cycle wrap and wraps at 128.
// - In external 8 kHz mode each external tick forces the offset to zero, unless the timer is loaded in that cycle.
// - The upper filter has a set port at 100h and a clear port at 104h, reads back, resets to 0.
// - Every packet bound for a request context from another bus or from local nodes 32..62 has its source checked against the filter.
// - A packet whose filter bit is zero is neither acknowledged nor queued.
// - The per-node check applies only when the source is on the local bus.
// - Requests from other buses pass only while filter bit 31 is one.
// - Filter bits 30..19 admit local nodes 62..51, node number being bit plus 32.
// - Filter bits 18..0 admit local nodes 50..32 in the same mapping.
//
// Implementation choice: strobed register access.
`timescale 1ns/100ps
module lctrf_top (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [11:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic ext_cycle_tick_pin,
  input wire logic cs_rx_valid,
  input wire logic [31:0] cs_rx_data,
  input wire logic cs_tx_req,
  output logic cs_tx_valid,
  output logic [31:0] cs_tx_data,
  output logic cycle_boundary,
  input wire logic [9:0] local_bus,
  input wire logic low_half_accept,
  input wire logic pkt_valid,
  input wire logic pkt_to_req_ctx,
  input wire logic [15:0] pkt_src_id,
  output logic pkt_decide_valid,
  output logic pkt_accept
);
  // Control and status state
  logic [2:0] ctrl_reg;
  logic [2:0] status_reg;
  logic [2:0] status_next;
  logic [31:0] filter_reg;
  logic [31:0] filter_next;
  logic [lctrf_pkg::REFUSED_W-1:0] refused_reg;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;

  // Decoded bus strobes
  logic wr_timer;
  logic wr_set;
  logic wr_clear;
  logic wr_ctrl;
  logic wr_status;
  logic wr_refused;

  // Control bits
  logic count_en;
  logic is_master;
  logic ext_mode;

  // Timer datapath
  logic [lctrf_pkg::FRAC_W-1:0] frac_reg;
  logic [lctrf_pkg::FRAC_W:0] frac_sum;
  logic frac_carry;
  logic [1:0] offset_step;
  logic [1:0] cycle_step;
  logic [1:0] seconds_step;
  logic timer_load;
  logic [31:0] timer_load_value;
  logic offset_clear;
  logic [lctrf_pkg::OFFSET_W-1:0] offset_val;
  logic [lctrf_pkg::CYCLE_W-1:0] cycle_val;
  logic [lctrf_pkg::SECONDS_W-1:0] seconds_val;
  logic offset_wrap;
  logic cycle_wrap;
  logic seconds_wrap;
  logic [31:0] timer_value;
  logic rx_load;

  // External tick synchroniser and edge detect
  logic ext_sync1_reg;
  logic ext_sync2_reg;
  logic ext_prev_reg;
  logic ext_tick;

  // Filter verdict from the checker
  logic decide_valid;
  logic decide_accept;

  assign count_en = ctrl_reg[lctrf_pkg::CTRL_COUNT_EN];
  assign is_master = ctrl_reg[lctrf_pkg::CTRL_CYCLE_MASTER];
  assign ext_mode = ctrl_reg[lctrf_pkg::CTRL_EXT_CLOCK];

  // Address decode of write strobes
  assign wr_timer = reg_wr && (reg_addr == lctrf_pkg::OFF_CYCLE_TIME);
  assign wr_set = reg_wr && (reg_addr == lctrf_pkg::OFF_FILT_SET);
  assign wr_clear = reg_wr && (reg_addr == lctrf_pkg::OFF_FILT_CLEAR);
  assign wr_ctrl = reg_wr && (reg_addr == lctrf_pkg::OFF_TIMER_CTRL);
  assign wr_status = reg_wr && (reg_addr == lctrf_pkg::OFF_TIMER_STATUS);
  assign wr_refused = reg_wr && (reg_addr == lctrf_pkg::OFF_REFUSED_COUNT);

  // Control register
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      ctrl_reg <= lctrf_pkg::CTRL_RESET;
    else if (wr_ctrl)
      ctrl_reg <= reg_wdata[2:0];
  end

  // Pin sync; only the second stage feeds the edge detector
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ext_sync1_reg <= 1'b0;
      ext_sync2_reg <= 1'b0;
      ext_prev_reg <= 1'b0;
    end
    else
    begin
      ext_sync1_reg <= ext_cycle_tick_pin;
      ext_sync2_reg <= ext_sync1_reg;
      ext_prev_reg <= ext_sync2_reg;
    end
  end

  assign ext_tick = ext_mode && ext_sync2_reg && !ext_prev_reg;

  // Fractional rate converter: 24.576 MHz ticks on a 20 MHz clock
  // gives one or two offset counts per cycle, never a drift
  assign frac_sum = {1'b0, frac_reg} + lctrf_pkg::FRAC_NUM;
  assign frac_carry = frac_sum >= lctrf_pkg::FRAC_DEN;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      frac_reg <= '0;
    else if (count_en)
    begin
      if (frac_carry)
        frac_reg <= lctrf_pkg::FRAC_W'(frac_sum - lctrf_pkg::FRAC_DEN);
      else
        frac_reg <= frac_sum[lctrf_pkg::FRAC_W-1:0];
    end
  end

  // Load sources: software first, then a received cycle start
  assign rx_load = cs_rx_valid && !is_master;
  assign timer_load = wr_timer || rx_load;
  assign timer_load_value = wr_timer ? reg_wdata : cs_rx_data;

  // Step chain between fields
  assign offset_step = count_en ? {frac_carry, !frac_carry} : 2'h0;
  assign offset_clear = ext_tick;
  assign cycle_step = {1'b0, offset_wrap || (ext_tick && count_en)};
  assign seconds_step = {1'b0, cycle_wrap};

  // Offset field
  lctrf_wrap_counter #(
    .WIDTH(lctrf_pkg::OFFSET_W),
    .MODULUS(lctrf_pkg::OFFSET_MOD)
  ) u_offset (
    .clk(clk),
    .rst_n(rst_n),
    .load(timer_load),
    .load_value(timer_load_value[lctrf_pkg::OFFSET_MSB:lctrf_pkg::OFFSET_LSB]),
    .clear(offset_clear),
    .step(offset_step),
    .value(offset_val),
    .wrap(offset_wrap)
  );

  // Cycle number field
  lctrf_wrap_counter #(
    .WIDTH(lctrf_pkg::CYCLE_W),
    .MODULUS(lctrf_pkg::CYCLE_MOD)
  ) u_cycle (
    .clk(clk),
    .rst_n(rst_n),
    .load(timer_load),
    .load_value(timer_load_value[lctrf_pkg::CYCLE_MSB:lctrf_pkg::CYCLE_LSB]),
    .clear(1'b0),
    .step(cycle_step),
    .value(cycle_val),
    .wrap(cycle_wrap)
  );

  // Seconds field
  lctrf_wrap_counter #(
    .WIDTH(lctrf_pkg::SECONDS_W),
    .MODULUS(lctrf_pkg::SECONDS_MOD)
  ) u_seconds (
    .clk(clk),
    .rst_n(rst_n),
    .load(timer_load),
    .load_value(timer_load_value[lctrf_pkg::SECONDS_MSB:lctrf_pkg::SECONDS_LSB]),
    .clear(1'b0),
    .step(seconds_step),
    .value(seconds_val),
    .wrap(seconds_wrap)
  );

  assign timer_value = {seconds_val, cycle_val, offset_val};

  // Snapshot for the transmitter, taken on request while master
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cs_tx_valid <= 1'b0;
      cs_tx_data <= '0;
    end
    else
    begin
      cs_tx_valid <= cs_tx_req && is_master;
      if (cs_tx_req && is_master)
        cs_tx_data <= timer_value;
    end
  end

  // Cycle boundary pulse lets the transmitter schedule cycle starts
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      cycle_boundary <= 1'b0;
    else
      cycle_boundary <= cycle_step[0] && !timer_load;
  end

  // Sticky status; a new event wins over a clear in the same cycle
  always_comb
  begin
    status_next = status_reg;
    if (wr_status)
      status_next = status_reg & ~reg_wdata[2:0];
    if (ext_tick)
      status_next[lctrf_pkg::STAT_EXT_TICK] = 1'b1;
    if (rx_load)
      status_next[lctrf_pkg::STAT_CS_RX] = 1'b1;
    if (cs_tx_req && is_master)
      status_next[lctrf_pkg::STAT_CS_TX] = 1'b1;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      status_reg <= '0;
    else
      status_reg <= status_next;
  end

  // Request filter set and clear ports; the strobes never coincide
  always_comb
  begin
    filter_next = filter_reg;
    if (wr_set)
      filter_next = filter_reg | reg_wdata;
    else if (wr_clear)
      filter_next = filter_reg & ~reg_wdata;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      filter_reg <= lctrf_pkg::FILT_RESET;
    else
      filter_reg <= filter_next;
  end

  // Source node check
  lctrf_req_filter u_filter (
    .clk(clk),
    .rst_n(rst_n),
    .filter_bits(filter_reg),
    .local_bus(local_bus),
    .low_half_accept(low_half_accept),
    .pkt_valid(pkt_valid),
    .pkt_to_req_ctx(pkt_to_req_ctx),
    .pkt_src_id(pkt_src_id),
    .decide_valid(decide_valid),
    .decide_accept(decide_accept)
  );

  assign pkt_decide_valid = decide_valid;
  assign pkt_accept = decide_accept;

  // Refused packet counter saturates rather than wrapping to hide losses
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      refused_reg <= '0;
    else if (decide_valid && !decide_accept && !(&refused_reg))
      refused_reg <= refused_reg + 1'b1;
    else if (wr_refused)
      refused_reg <= '0;
  end

  // Read mux; unmapped addresses return zero
  always_comb
  begin
    rdata_next = '0;
    unique case (reg_addr)
      lctrf_pkg::OFF_CYCLE_TIME: rdata_next = timer_value;
      lctrf_pkg::OFF_FILT_SET: rdata_next = filter_reg;
      lctrf_pkg::OFF_FILT_CLEAR: rdata_next = filter_reg;
      lctrf_pkg::OFF_TIMER_CTRL: rdata_next = {29'h0, ctrl_reg};
      lctrf_pkg::OFF_TIMER_STATUS: rdata_next = {29'h0, status_reg};
      lctrf_pkg::OFF_REFUSED_COUNT: rdata_next = {16'h0, refused_reg};
      default: rdata_next = '0;
    endcase
  end

  // Read data stands for exactly one cycle after the strobe
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      rdata_reg <= '0;
    else if (reg_rd)
      rdata_reg <= rdata_next;
    else
      rdata_reg <= '0;
  end

  assign reg_rdata = rdata_reg;
endmodule

// File: logic/lctrf_wrap_counter.sv
// Modulo counter with load, clear and a step of zero to three
`timescale 1ns/100ps
module lctrf_wrap_counter #(
  parameter int WIDTH = 12,
  parameter logic [WIDTH:0] MODULUS = '1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic load,
  input wire logic [WIDTH-1:0] load_value,
  input wire logic clear,
  input wire logic [1:0] step,
  output logic [WIDTH-1:0] value,
  output logic wrap
);
  logic [WIDTH-1:0] value_reg;
  logic [WIDTH:0] sum;

  // Sum one bit wider so the wrap test cannot overflow
  assign sum = {1'b0, value_reg} + {{(WIDTH-1){1'b0}}, step};
  assign wrap = !load && !clear && (sum >= MODULUS);
  assign value = value_reg;

  // Load beats clear beats step
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      value_reg <= '0;
    else if (load)
      value_reg <= load_value;
    else if (clear)
      value_reg <= '0;
    else if (wrap)
      value_reg <= WIDTH'(sum - MODULUS);
    else
      value_reg <= sum[WIDTH-1:0];
  end
endmodule

// File: verification/lctrf_bus_model.sv
// Serial bus side model: cycle starts, packet sources, 8 kHz tick
`timescale 1ns/100ps
module lctrf_bus_model (
  input wire logic clk,
  output logic cs_rx_valid,
  output logic [31:0] cs_rx_data,
  output logic cs_tx_req,
  output logic ext_cycle_tick_pin,
  output logic pkt_valid,
  output logic pkt_to_req_ctx,
  output logic [15:0] pkt_src_id,
  output logic low_half_accept
);
  // Idle values at time zero
  initial
  begin
    cs_rx_valid = 1'b0;
    cs_rx_data = 32'h0;
    cs_tx_req = 1'b0;
    ext_cycle_tick_pin = 1'b0;
    pkt_valid = 1'b0;
    pkt_to_req_ctx = 1'b0;
    pkt_src_id = 16'h0;
    low_half_accept = 1'b0;
  end
  // Data inverted after the pulse so stale values never look valid
  task automatic send_cs(input logic [31:0] d);
    @(posedge clk);
    cs_rx_valid <= 1'b1;
    cs_rx_data <= d;
    @(posedge clk);
    cs_rx_valid <= 1'b0;
    cs_rx_data <= ~d;
  endtask
  task automatic req_tx();
    @(posedge clk);
    cs_tx_req <= 1'b1;
    @(posedge clk);
    cs_tx_req <= 1'b0;
  endtask
  task automatic send_pkt(input logic [15:0] src, input logic req, input logic low);
    @(posedge clk);
    pkt_valid <= 1'b1;
    pkt_src_id <= src;
    pkt_to_req_ctx <= req;
    low_half_accept <= low;
    @(posedge clk);
    pkt_valid <= 1'b0;
    pkt_src_id <= ~src;
    pkt_to_req_ctx <= ~req;
    low_half_accept <= ~low;
  endtask
  // Shortened tick, long enough for the two-stage sync
  task automatic tick();
    @(posedge clk);
    ext_cycle_tick_pin <= 1'b1;
    repeat (4) @(posedge clk);
    ext_cycle_tick_pin <= 1'b0;
  endtask
endmodule

// File: verification/lctrf_checker.sv
// Port checker for the cycle timer and request filter block
`timescale 1ns/100ps
module lctrf_checker (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [11:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic cs_tx_req,
  input wire logic cs_tx_valid,
  input wire logic [31:0] cs_tx_data,
  input wire logic [9:0] local_bus,
  input wire logic low_half_accept,
  input wire logic pkt_valid,
  input wire logic pkt_to_req_ctx,
  input wire logic [15:0] pkt_src_id,
  input wire logic pkt_decide_valid,
  input wire logic pkt_accept
);
  logic [31:0] filt_reg;
  logic loc;
  logic nbit;
  logic rbit;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Own copy of the filter, fed only by the two ports
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      filt_reg <= 32'h0;
    else if (reg_wr && reg_addr == 12'h100)
      filt_reg <= filt_reg | reg_wdata;
    else if (reg_wr && reg_addr == 12'h104)
      filt_reg <= filt_reg & ~reg_wdata;
  end
  // Bus 3ffh is an alias of the local bus
  assign loc = pkt_src_id[15:6] == local_bus || pkt_src_id[15:6] == 10'h3ff;
  assign nbit = filt_reg[pkt_src_id[4:0]];
  assign rbit = filt_reg[31];
  sequence req_s;
    pkt_valid && pkt_to_req_ctx;
  endsequence
  chk_filter_read: assert property (
    $past(reg_rd) && ($past(reg_addr) == 12'h100 || $past(reg_addr) == 12'h104)
    |-> reg_rdata == $past(filt_reg)) else $error("filter readback wrong");
  chk_rdata_idle: assert property (
    !$past(reg_rd) |-> reg_rdata == 32'h0) else $error("read data not idle");
  chk_decide_time: assert property (
    pkt_decide_valid == $past(pkt_valid)) else $error("decision timing wrong");
  chk_pass_other: assert property (
    pkt_valid && !pkt_to_req_ctx |=> pkt_accept) else $error("non-request refused");
  chk_node_map: assert property (
    req_s ##0 (loc && pkt_src_id[5] && pkt_src_id[5:0] != 6'h3f)
    |=> pkt_accept == $past(nbit)) else $error("node bit not applied");
  chk_node_top: assert property (
    req_s ##0 (loc && pkt_src_id[5:0] == 6'h3f) |=> !pkt_accept)
    else $error("node 63 accepted");
  chk_low_half: assert property (
    req_s ##0 (loc && !pkt_src_id[5]) |=> pkt_accept == $past(low_half_accept))
    else $error("low half verdict lost");
  chk_remote_bit: assert property (
    req_s ##0 !loc |=> pkt_accept == $past(rbit)) else $error("remote verdict wrong");
  chk_tx_cause: assert property (
    cs_tx_valid |-> $past(cs_tx_req)) else $error("cycle start without request");
  chk_tx_hold: assert property (
    !cs_tx_valid |-> $stable(cs_tx_data)) else $error("cycle start data moved");
endmodule

// File: verification/lctrf_tb_top.sv
// Testbench top for the cycle timer and request filter block
`timescale 1ns/100ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin errors++; \
  $display("[ERR] %0t got %h exp %h", $time, (a), (b)); end end
module lctrf_tb_top;
  logic clk, rst_n, reg_wr, reg_rd, cs_rx_valid, cs_tx_req, cs_tx_valid;
  logic ext_cycle_tick_pin, pkt_valid, pkt_to_req_ctx, low_half_accept;
  logic pkt_decide_valid, pkt_accept, cycle_boundary;
  logic [11:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, cs_rx_data, cs_tx_data, rd;
  logic [9:0] local_bus;
  logic [15:0] pkt_src_id;
  int errors, samples_checked;
  int boundaries, b0;
  lctrf_top i_lctrf_top (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .ext_cycle_tick_pin, .cs_rx_valid, .cs_rx_data, .cs_tx_req,
    .cs_tx_valid, .cs_tx_data, .cycle_boundary, .local_bus, .low_half_accept,
    .pkt_valid, .pkt_to_req_ctx, .pkt_src_id, .pkt_decide_valid, .pkt_accept);
  lctrf_bus_model i_lctrf_bus_model (.clk, .cs_rx_valid, .cs_rx_data, .cs_tx_req,
    .ext_cycle_tick_pin, .pkt_valid, .pkt_to_req_ctx, .pkt_src_id, .low_half_accept);
  // 50 ns clock
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Count boundary pulses mid-cycle, where the registered pulse has settled
  always @(negedge clk)
  begin
    if (cycle_boundary === 1'b1)
      boundaries++;
  end
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // Read data stands only in the cycle after the strobe
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 rd = reg_rdata;
    `CHK(rd & m, e)
  endtask
  task automatic pkt(input logic [15:0] s, input logic q, input logic l, input logic e);
    i_lctrf_bus_model.send_pkt(s, q, l);
    #1 `CHK({pkt_decide_valid, pkt_accept}, {1'b1, e})
  endtask
  task automatic end_of_test();
    if (errors == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Watchdog against a hung sequence
  initial
  begin
    repeat (50000) @(posedge clk);
    errors++;
    end_of_test();
  end
  initial
  begin
    rst_n = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 12'h0;
    reg_wdata = 32'h0;
    local_bus = 10'h005;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    rd_chk(12'h100, '1, 32'h0);
    rd_chk(12'h0f0, '1, 32'h0);
    rd_chk(12'h3fc, '1, 32'h0);
    wr(12'h100, 32'h8008_0003);
    wr(12'h104, 32'h0000_0002);
    rd_chk(12'h104, '1, 32'h8008_0001);
    rd_chk(12'h100, '1, 32'h8008_0001);
    pkt({10'h005, 6'h33}, 1'b1, 1'b0, 1'b1);
    pkt({10'h005, 6'h3e}, 1'b1, 1'b1, 1'b0);
    pkt({10'h005, 6'h20}, 1'b1, 1'b0, 1'b1);
    pkt({10'h005, 6'h21}, 1'b1, 1'b1, 1'b0);
    pkt({10'h005, 6'h3f}, 1'b1, 1'b1, 1'b0);
    pkt({10'h3ff, 6'h33}, 1'b1, 1'b0, 1'b1);
    pkt({10'h011, 6'h21}, 1'b1, 1'b0, 1'b1);
    pkt({10'h005, 6'h05}, 1'b1, 1'b1, 1'b1);
    pkt({10'h005, 6'h05}, 1'b1, 1'b0, 1'b0);
    pkt({10'h005, 6'h3e}, 1'b0, 1'b0, 1'b1);
    wr(12'h104, 32'h8000_0000);
    pkt({10'h011, 6'h21}, 1'b1, 1'b1, 1'b0);
    pkt({10'h011, 6'h33}, 1'b1, 1'b1, 1'b0);
    // Move the own bus number so local and remote swap roles
    @(posedge clk);
    local_bus <= 10'h011;
    pkt({10'h011, 6'h33}, 1'b1, 1'b0, 1'b1);
    pkt({10'h005, 6'h33}, 1'b1, 1'b1, 1'b0);
    rd_chk(12'h118, '1, 32'h7);
    wr(12'h0f0, 32'h0a12_3456);
    rd_chk(12'h0f0, '1, 32'h0a12_3456);
    // Just short of all three wraps, then count a little
    b0 = boundaries;
    wr(12'h0f0, 32'hfff3_fbfe);
    wr(12'h110, 32'h1);
    repeat (20) @(posedge clk);
    wr(12'h110, 32'h0);
    rd_chk(12'h0f0, 32'hffff_ffc0, 32'h0);
    `CHK(boundaries - b0, 1)
    // About 1229 offset counts expected over 1000 cycles
    wr(12'h0f0, 32'h0);
    wr(12'h110, 32'h1);
    repeat (1000) @(posedge clk);
    wr(12'h110, 32'h0);
    `CHK(reg_rdata, 32'h0)
    rd_chk(12'h0f0, 32'hffff_f000, 32'h0);
    `CHK(rd >= 32'h4c8 && rd <= 32'h4e0, 1'b1)
    i_lctrf_bus_model.send_cs(32'h1c0d_0a0b);
    rd_chk(12'h0f0, '1, 32'h1c0d_0a0b);
    wr(12'h110, 32'h2);
    i_lctrf_bus_model.send_cs(32'h0);
    i_lctrf_bus_model.req_tx();
    #1 `CHK({cs_tx_valid, cs_tx_data}, {1'b1, 32'h1c0d_0a0b})
    rd_chk(12'h0f0, '1, 32'h1c0d_0a0b);
    b0 = boundaries;
    wr(12'h0f0, 32'h0000_0800);
    wr(12'h110, 32'h5);
    i_lctrf_bus_model.tick();
    repeat (6) @(posedge clk);
    wr(12'h110, 32'h0);
    rd_chk(12'h0f0, 32'hffff_ffe0, 32'h0000_1000);
    `CHK(boundaries - b0, 1)
    // Sticky status: tick seen, cycle start loaded, cycle start sent
    rd_chk(12'h114, '1, 32'h7);
    wr(12'h114, 32'h7);
    rd_chk(12'h114, '1, 32'h0);
    end_of_test();
  end
endmodule
bind lctrf_top lctrf_checker i_lctrf_checker (.clk, .rst_n, .reg_addr, .reg_wdata,
  .reg_wr, .reg_rd, .reg_rdata, .cs_tx_req, .cs_tx_valid, .cs_tx_data, .local_bus,
  .low_half_accept, .pkt_valid, .pkt_to_req_ctx, .pkt_src_id, .pkt_decide_valid,
  .pkt_accept);
